//--- wfs_status_regs.sv
/*
 * wfs_status_regs: latched warning flags, junction temperature and field
 * strength, read by the serial front end through a byte-address read port.
 * assumes: all inputs come from logic on core_clk_i; the serial front end
 * decodes frames and pulses clear and turns-reset requests.
 */
//Function
// R1: every warning flag except turns overflow (bit 0) latches high until the host reads and clears it
// R2: bits 15:12 carry ids 1011, 1111, 1110 for the three registers
// R3: bad bit count or MOSI bit 15 sets bit 11 and drops packet; Manchester error sets bit 11 only
// R4: with CRC checking enabled a bad CRC drops packet and sets bit 10
// R5: slew limiting enabled and active sets bit 8
// R6: extended command failing, locked or EEPROM write fail, sets bit 7
// R7: temperature beyond -60..180 C sets bit 6 and clamps to the limit
// R8: corrected single-bit EEPROM error during load sets bit 5
// R9: any internal saturation source sets bit 4
// R10: over 135 degrees change between turns updates sets bit 3
// R11: extended access started while previous busy sets bit 2
// R12: field above configured high threshold sets bit 1
// R13: turns overflow sets bit 0; only turns-count reset clears it
// R14: temperature is signed eighth-degrees relative to 25 C in bits 11:0
// R15: field register holds gauss in bits 11:0, refreshed every 128 us
// R16: summary warning bit is high when any unmasked warning flag is set
// R17: host clear drops all flags but turns overflow; live conditions stay set
`timescale 1ns/100ps
`default_nettype none
module wfs_status_regs
    import wfs_pkg::*;
#(
    parameter int FIELD_PERIOD = wfs_pkg::FIELD_PERIOD_CYC
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 ce_i,
    input  wire wfs_pkg::wfs_events_t events_i,
    input  wire wfs_pkg::wfs_config_t config_i,
    input  wire logic                 rd_en_i,
    input  wire logic [7:0]           rd_addr_i,
    input  wire logic                 clear_i,
    input  wire logic                 turns_reset_i,
    output logic [15:0]               rd_data_o,
    output logic                      rd_valid_o,
    output logic                      pkt_accept_o,
    output logic                      summary_warning_bit_o
);
    import wfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // shortest circular distance between two 12-bit angles
    function automatic logic [11:0] angle_dist(input logic [11:0] a, input logic [11:0] b);
        logic [11:0] d;
        d = a - b;
        angle_dist = d[11] ? 12'(~d + 12'h001) : d;
    endfunction

    // word register decode, tolerant of either byte of the pair
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] base);
        addr_hit = (addr[7:1] == base[7:1]);
    endfunction

    localparam logic [FIELD_CNT_W-1:0] FIELD_LAST = FIELD_CNT_W'(FIELD_PERIOD - 1);

    wfs_state_t  st;
    wfs_state_t  next_st;
    logic [11:0] set_vec;
    logic [11:0] clr_vec;
    logic        iface_err;
    logic        crc_err;
    logic        temp_low;
    logic        temp_high;
    logic [11:0] flags_now;

    ////////////////////////////////////////////////////////////////////////////
    // event detection

    always_comb begin
        set_vec   = 12'h000;
        iface_err = events_i.pkt_done & (events_i.pkt_bit_count_bad | events_i.pkt_mosi_bit15); // see R3
        crc_err   = events_i.pkt_done & config_i.crc_check_enable & events_i.pkt_crc_bad;   // see R4
        temp_low  = events_i.temp_valid & (events_i.temp_calc < TEMP_MIN_CODE);             // see R7
        temp_high = events_i.temp_valid & (events_i.temp_calc > TEMP_MAX_CODE);             // see R7

        set_vec[BIT_INTERFACE_ERROR]   = iface_err | events_i.manchester_error;              // see R3
        set_vec[BIT_CRC_ERROR]         = crc_err;                                            // see R4
        set_vec[BIT_SLEW_LIMIT]        = config_i.slew_limit_enable & events_i.slew_limit_active; // see R5
        set_vec[BIT_EXTENDED_EXECUTE]  = events_i.ext_cmd_done &
                                         (~events_i.ext_unlocked | events_i.ext_eeprom_fail); // see R6
        set_vec[BIT_TEMPERATURE_RANGE] = temp_low | temp_high;                               // see R7
        set_vec[BIT_EEPROM_SOFT]       = events_i.eeprom_loading & events_i.eeprom_corrected; // see R8
        set_vec[BIT_SATURATION]        = |events_i.saturation;                               // see R9
        set_vec[BIT_TURNS_JUMP]        = events_i.turns_update & st.angle_seen &
                                         (angle_dist(events_i.turns_angle, st.last_angle) > TURNS_JUMP_CODE); // see R10
        set_vec[BIT_EXTENDED_OVERFLOW] = events_i.ext_start & events_i.ext_busy;            // see R11
        set_vec[BIT_FIELD_HIGH]        = st.field > config_i.field_high_threshold;          // see R12
        set_vec[BIT_TURNS_OVERFLOW]    = events_i.turns_overflow;                            // see R13
        set_vec                        = set_vec & FLAG_IMPLEMENTED;
    end

    // clear masks: host clear spares turns overflow, which only turns reset drops
    always_comb begin
        clr_vec = 12'h000;
        if (clear_i) begin
            clr_vec = FLAG_IMPLEMENTED;                                                      // see R17
            clr_vec[BIT_TURNS_OVERFLOW] = 1'b0;                                              // see R13
        end
        if (turns_reset_i) begin
            clr_vec[BIT_TURNS_OVERFLOW] = 1'b1;                                              // see R13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st = st;

        // set beats clear, so a live condition is never lost across a clear
        flags_now     = (st.flags & ~clr_vec) | set_vec;                                     // see R1
        next_st.flags = flags_now;                                                           // see R17

        // unmasked flags roll up into the summary bit
        next_st.summary = |(flags_now & ~config_i.warning_mask);                            // see R16

        // a packet is forwarded only if neither the framing nor the CRC check failed
        next_st.pkt_accept = events_i.pkt_done & ~iface_err & ~crc_err;                      // see R3 see R4

        // temperature clamps to the violated limit
        if (events_i.temp_valid) begin
            if (temp_low) begin
                next_st.temperature = TEMP_MIN_CODE[11:0];                                   // see R7
            end else if (temp_high) begin
                next_st.temperature = TEMP_MAX_CODE[11:0];                                   // see R7
            end else begin
                next_st.temperature = events_i.temp_calc[11:0];                              // see R14
            end
        end

        // field sampled on a fixed period; reads between samples see the old value
        if (st.field_cnt == FIELD_LAST) begin
            next_st.field_cnt = '0;
            next_st.field     = events_i.field_gauss;                                        // see R15
        end else begin
            next_st.field_cnt = st.field_cnt + 1'b1;
        end

        // angle reference for the jump check; first update only seeds it
        if (events_i.turns_update) begin
            next_st.last_angle = events_i.turns_angle;                                       // see R10
            next_st.angle_seen = 1'b1;
        end
        if (turns_reset_i) begin
            next_st.angle_seen = 1'b0;
        end

        // read port, one-cycle answer; unmapped addresses read zero
        next_st.rd_valid = rd_en_i;
        if (rd_en_i) begin
            if (addr_hit(rd_addr_i, ADDR_WARNING_FLAGS)) begin
                next_st.rd_data = {ID_WARNING, st.flags & FLAG_IMPLEMENTED};                 // see R2
            end else if (addr_hit(rd_addr_i, ADDR_JUNCTION_TEMPERATURE)) begin
                next_st.rd_data = {ID_TEMPERATURE, st.temperature};                          // see R2 see R14
            end else if (addr_hit(rd_addr_i, ADDR_FIELD_STRENGTH)) begin
                next_st.rd_data = {ID_FIELD, st.field};                                      // see R2 see R15
            end else begin
                next_st.rd_data = RST_RD_DATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st.flags       <= RST_FLAGS;
            st.temperature <= RST_TEMPERATURE;
            st.field       <= RST_FIELD;
            st.field_cnt   <= '0;
            st.last_angle  <= 12'h000;
            st.angle_seen  <= 1'b0;
            st.rd_data     <= RST_RD_DATA;
            st.rd_valid    <= 1'b0;
            st.summary     <= 1'b0;
            st.pkt_accept  <= 1'b0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign rd_data_o             = st.rd_data;
    assign rd_valid_o            = st.rd_valid;
    assign pkt_accept_o          = st.pkt_accept;
    assign summary_warning_bit_o = st.summary;

endmodule
`default_nettype wire

//--- wfs_pkg.sv
/*
 * wfs_pkg: constants and carrier types for the warning, temperature and
 * field-strength status registers.
 * assumes: included first; every user imports the whole package.
 */
`default_nettype none
package wfs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses, first byte of each 16-bit word
    localparam logic [7:0]  ADDR_WARNING_FLAGS        = 8'h26;
    localparam logic [7:0]  ADDR_JUNCTION_TEMPERATURE = 8'h28;
    localparam logic [7:0]  ADDR_FIELD_STRENGTH       = 8'h2a;

    // register identifiers in bits 15:12
    localparam int          ID_LSB          = 12;
    localparam logic [3:0]  ID_WARNING      = 4'hb;
    localparam logic [3:0]  ID_TEMPERATURE  = 4'hf;
    localparam logic [3:0]  ID_FIELD        = 4'he;

    // warning flag positions
    localparam int          FLAG_W                 = 12;
    localparam int          BIT_INTERFACE_ERROR    = 11;
    localparam int          BIT_CRC_ERROR          = 10;
    localparam int          BIT_SLEW_LIMIT         = 8;
    localparam int          BIT_EXTENDED_EXECUTE   = 7;
    localparam int          BIT_TEMPERATURE_RANGE  = 6;
    localparam int          BIT_EEPROM_SOFT        = 5;
    localparam int          BIT_SATURATION         = 4;
    localparam int          BIT_TURNS_JUMP         = 3;
    localparam int          BIT_EXTENDED_OVERFLOW  = 2;
    localparam int          BIT_FIELD_HIGH         = 1;
    localparam int          BIT_TURNS_OVERFLOW     = 0;
    // bit 9 is unused and reads zero
    localparam logic [11:0] FLAG_IMPLEMENTED       = 12'hdff;

    // reset values
    localparam logic [11:0] RST_FLAGS       = 12'h000;
    localparam logic [11:0] RST_TEMPERATURE = 12'h000;
    localparam logic [11:0] RST_FIELD       = 12'h000;
    localparam logic [15:0] RST_RD_DATA     = 16'h0000;

    // temperature, eighth-degree steps relative to 25 C
    localparam int          TEMP_STEPS_PER_DEG = 8;
    localparam int          TEMP_OFFSET_DEG    = 25;
    localparam int          TEMP_MIN_DEG       = -60;
    localparam int          TEMP_MAX_DEG       = 180;
    localparam logic signed [15:0] TEMP_MIN_CODE =
        16'((TEMP_MIN_DEG - TEMP_OFFSET_DEG) * TEMP_STEPS_PER_DEG);
    localparam logic signed [15:0] TEMP_MAX_CODE =
        16'((TEMP_MAX_DEG - TEMP_OFFSET_DEG) * TEMP_STEPS_PER_DEG);

    // turns jump limit in 12-bit angle codes (full turn is 4096)
    localparam int          ANGLE_FULL_TURN  = 4096;
    localparam int          TURNS_JUMP_DEG   = 135;
    localparam logic [11:0] TURNS_JUMP_CODE  = 12'(TURNS_JUMP_DEG * ANGLE_FULL_TURN / 360);

    // field refresh period
    localparam int          CLK_MHZ          = 250;
    localparam int          FIELD_PERIOD_US  = 128;
    localparam int          FIELD_PERIOD_CYC = FIELD_PERIOD_US * CLK_MHZ;
    localparam int          FIELD_CNT_W      = 16;
    localparam logic [11:0] FIELD_HIGH_DEFAULT = 12'h4b0;

    localparam int          SAT_SOURCES      = 4;

    ////////////////////////////////////////////////////////////////////////////
    // event inputs from the surrounding device logic
    typedef struct packed {
        logic                   pkt_done;
        logic                   pkt_bit_count_bad;
        logic                   pkt_mosi_bit15;
        logic                   manchester_error;
        logic                   pkt_crc_bad;
        logic                   slew_limit_active;
        logic                   ext_cmd_done;
        logic                   ext_unlocked;
        logic                   ext_eeprom_fail;
        logic                   ext_start;
        logic                   ext_busy;
        logic                   eeprom_loading;
        logic                   eeprom_corrected;
        logic [SAT_SOURCES-1:0] saturation;
        logic                   turns_update;
        logic [11:0]            turns_angle;
        logic                   turns_overflow;
        logic                   temp_valid;
        logic signed [15:0]     temp_calc;
        logic [11:0]            field_gauss;
    } wfs_events_t;

    // stored configuration
    typedef struct packed {
        logic                   crc_check_enable;
        logic                   slew_limit_enable;
        logic [11:0]            field_high_threshold;
        logic [11:0]            warning_mask;
    } wfs_config_t;

    // complete state of the register bank
    typedef struct packed {
        logic [11:0]            flags;
        logic [11:0]            temperature;
        logic [11:0]            field;
        logic [FIELD_CNT_W-1:0] field_cnt;
        logic [11:0]            last_angle;
        logic                   angle_seen;
        logic [15:0]            rd_data;
        logic                   rd_valid;
        logic                   summary;
        logic                   pkt_accept;
    } wfs_state_t;

endpackage
`default_nettype wire

//--- HANDOVER_END_UNUSED.sv
`default_nettype none
`default_nettype wire

//--- wfs_status_regs_properties.sv
/* port checker for the status register bank.
   assumes: bound to wfs_status_regs, one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module wfs_status_regs_properties
    import wfs_pkg::*;
(
    input  wire logic                 core_clk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 ce_i,
    input  wire wfs_pkg::wfs_events_t events_i,
    input  wire wfs_pkg::wfs_config_t config_i,
    input  wire logic                 rd_en_i,
    input  wire logic [7:0]           rd_addr_i,
    input  wire logic                 clear_i,
    input  wire logic                 turns_reset_i,
    input  wire logic [15:0]          rd_data_o,
    input  wire logic                 rd_valid_o,
    input  wire logic                 pkt_accept_o,
    input  wire logic                 summary_warning_bit_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic rd;
    logic bad;
    logic irq_cause;
    assign rd = ce_i && rd_en_i;
    assign bad = events_i.pkt_bit_count_bad || events_i.pkt_mosi_bit15
               || (events_i.pkt_crc_bad && config_i.crc_check_enable);
    assign irq_cause = ce_i && events_i.manchester_error && !config_i.warning_mask[11];
    ////////////////////////////////////////////////////////////////////////////
    read_answer_a: assert property (rd |=> rd_valid_o)
        else $error("read not answered");
    valid_pulse_a: assert property (ce_i && !rd_en_i |=> !rd_valid_o)
        else $error("stray read valid");
    warn_id_a: assert property (rd && rd_addr_i[7:1] == 7'h13 |=> rd_data_o[15:12] == 4'hb && !rd_data_o[9])
        else $error("warning word id wrong");
    temp_id_a: assert property (rd && rd_addr_i[7:1] == 7'h14 |=> rd_data_o[15:12] == 4'hf)
        else $error("temperature word id wrong");
    field_id_a: assert property (rd && rd_addr_i[7:1] == 7'h15 |=> rd_data_o[15:12] == 4'he)
        else $error("field word id wrong");
    unmapped_zero_a: assert property (rd && (rd_addr_i[7:1] < 7'h13 || rd_addr_i[7:1] > 7'h15) |=> rd_data_o == 16'h0000)
        else $error("unmapped read not zero");
    iface_flag_a: assert property (irq_cause |=> summary_warning_bit_o)
        else $error("interface error not flagged");
    latch_hold_a: assert property (irq_cause ##1 ce_i && !clear_i |=> summary_warning_bit_o)
        else $error("flag did not stay latched");
    bad_pkt_a: assert property (ce_i && events_i.pkt_done && bad |=> !pkt_accept_o)
        else $error("bad packet accepted");
    good_pkt_a: assert property (ce_i && events_i.pkt_done && !bad |=> pkt_accept_o)
        else $error("good packet dropped");
    // clock enable low must freeze read data, read valid and the summary bit
    freeze_hold_a: assert property (!ce_i |=> $stable(rd_data_o) && $stable(rd_valid_o) && $stable(summary_warning_bit_o))
        else $error("outputs moved while frozen");
endmodule
bind wfs_status_regs wfs_status_regs_properties i_props (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .events_i(events_i),
    .config_i(config_i), .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .clear_i(clear_i),
    .turns_reset_i(turns_reset_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .pkt_accept_o(pkt_accept_o), .summary_warning_bit_o(summary_warning_bit_o));
`default_nettype wire

//--- wfs_host_model.sv
/* host side model: register reads, flag clear and turns-count reset.
   assumes: same clock as the bank; one read in flight at a time. */
`timescale 1ns/100ps
`default_nettype none
module wfs_host_model
    import wfs_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic [15:0] rd_data_i,
    input  wire logic        rd_valid_i,
    output logic             rd_en_o,
    output logic [7:0]       rd_addr_o,
    output logic             clear_o,
    output logic             turns_reset_o
);
    initial begin
        rd_en_o = 1'b0;
        rd_addr_o = 8'h00;
        clear_o = 1'b0;
        turns_reset_o = 1'b0;
    end
    // answer stands one cycle only, so it is taken once, settled
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk_i);
        rd_en_o <= 1'b1;
        rd_addr_o <= a;
        @(posedge core_clk_i);
        rd_en_o <= 1'b0;
        rd_addr_o <= ~a;
        @(negedge core_clk_i);
        d = (rd_valid_i === 1'b1) ? rd_data_i : 16'hxxxx;
    endtask
    task automatic clear_flags();
        @(posedge core_clk_i);
        clear_o <= 1'b1;
        @(posedge core_clk_i);
        clear_o <= 1'b0;
    endtask
    task automatic turns_reset();
        @(posedge core_clk_i);
        turns_reset_o <= 1'b1;
        @(posedge core_clk_i);
        turns_reset_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- tb_warning_temp_field_status_regs.sv
/* self-checking bench for the status register bank.
   assumes: host model drives reads and clears; bench drives events. */
`timescale 1ns/100ps
`default_nettype none
module tb_warning_temp_field_status_regs;
    import wfs_pkg::*;
    localparam int FP = 16;
    logic        clk;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    wfs_events_t ev = '0;
    wfs_config_t cfg = '{1'b1, 1'b1, FIELD_HIGH_DEFAULT, 12'h000};
    logic        rd_en;
    logic [7:0]  rd_addr;
    logic        clr;
    logic        trst;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        acc;
    logic        summ;
    int          fail_count = 0;
    int          compares = 0;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    wfs_status_regs #(.FIELD_PERIOD(FP)) i_dut (.core_clk_i(clk), .sys_rst_i(rst), .ce_i(ce),
        .events_i(ev), .config_i(cfg), .rd_en_i(rd_en), .rd_addr_i(rd_addr), .clear_i(clr),
        .turns_reset_i(trst), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .pkt_accept_o(acc),
        .summary_warning_bit_o(summ));
    wfs_host_model i_host (.core_clk_i(clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
        .rd_en_o(rd_en), .rd_addr_o(rd_addr), .clear_o(clr), .turns_reset_o(trst));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk16(input logic [15:0] g, input logic [15:0] x);
        compares++;
        if (g !== x) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic chk1(input logic g, input logic x);
        chk16({15'h0000, g}, {15'h0000, x});
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] x);
        logic [15:0] d;
        i_host.read(a, d);
        chk16(d, x);
    endtask
    // one-cycle event, then read the warning word back and clear it
    task automatic ev_check(input wfs_events_t e, input logic [15:0] x, input logic a);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= '0;
        @(negedge clk);
        chk1(acc, a);
        rd_chk(8'h26, x);
        chk1(summ, |(x[11:0] & ~cfg.warning_mask));
        i_host.clear_flags();
    endtask
    task automatic end_sim();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(8'h26, 16'hb000);
        rd_chk(8'h28, 16'hf000);
        rd_chk(8'h2a, 16'he000);
        rd_chk(8'h27, 16'hb000);
        rd_chk(8'h40, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_packet();
        wfs_events_t e;
        e = '0;
        e.pkt_done = 1'b1;
        ev_check(e, 16'hb000, 1'b1);
        e.pkt_crc_bad = 1'b1;
        ev_check(e, 16'hb400, 1'b0);
        cfg.crc_check_enable <= 1'b0;
        ev_check(e, 16'hb000, 1'b1);
        e.pkt_bit_count_bad = 1'b1;
        ev_check(e, 16'hb800, 1'b0);
        e.pkt_bit_count_bad = 1'b0;
        e.pkt_mosi_bit15 = 1'b1;
        ev_check(e, 16'hb800, 1'b0);
        e = '0;
        e.manchester_error = 1'b1;
        ev_check(e, 16'hb800, 1'b0);
        cfg.warning_mask <= 12'h800;
        ev_check(e, 16'hb800, 1'b0);
        cfg.warning_mask <= 12'h000;
        $display("test packet done");
    endtask
    task automatic t_events();
        wfs_events_t e;
        e = '0;
        e.slew_limit_active = 1'b1;
        ev_check(e, 16'hb100, 1'b0);
        cfg.slew_limit_enable <= 1'b0;
        ev_check(e, 16'hb000, 1'b0);
        e = '0;
        e.ext_cmd_done = 1'b1;
        ev_check(e, 16'hb080, 1'b0);
        e.ext_unlocked = 1'b1;
        e.ext_eeprom_fail = 1'b1;
        ev_check(e, 16'hb080, 1'b0);
        e.ext_eeprom_fail = 1'b0;
        ev_check(e, 16'hb000, 1'b0);
        e = '0;
        e.eeprom_loading = 1'b1;
        e.eeprom_corrected = 1'b1;
        ev_check(e, 16'hb020, 1'b0);
        e.eeprom_loading = 1'b0;
        ev_check(e, 16'hb000, 1'b0);
        e = '0;
        e.saturation = 4'h8;
        ev_check(e, 16'hb010, 1'b0);
        e = '0;
        e.ext_start = 1'b1;
        e.ext_busy = 1'b1;
        ev_check(e, 16'hb004, 1'b0);
        e.ext_busy = 1'b0;
        ev_check(e, 16'hb000, 1'b0);
        e = '0;
        e.temp_valid = 1'b1;
        e.temp_calc = 16'sh04d8;
        ev_check(e, 16'hb000, 1'b0);
        rd_chk(8'h28, 16'hf4d8);
        e.temp_calc = -16'sh02bc;
        ev_check(e, 16'hb040, 1'b0);
        rd_chk(8'h28, 16'hfd58);
        e = '0;
        e.turns_update = 1'b1;
        ev_check(e, 16'hb000, 1'b0);
        e.turns_angle = 12'h700;
        ev_check(e, 16'hb008, 1'b0);
        e.turns_angle = 12'hd00;
        ev_check(e, 16'hb000, 1'b0);
        e = '0;
        e.turns_overflow = 1'b1;
        ev_check(e, 16'hb001, 1'b0);
        rd_chk(8'h26, 16'hb001);
        i_host.turns_reset();
        rd_chk(8'h26, 16'hb000);
        $display("test events done");
    endtask
    // refresh is periodic, so waits cover one full period plus read latency
    task automatic t_field();
        @(posedge clk);
        ev.field_gauss <= 12'h4b1;
        repeat (FP + 1) @(posedge clk);
        rd_chk(8'h2a, 16'he4b1);
        rd_chk(8'h26, 16'hb002);
        @(posedge clk);
        ev.field_gauss <= 12'h4b0;
        repeat (FP + 1) @(posedge clk);
        i_host.clear_flags();
        rd_chk(8'h26, 16'hb000);
        rd_chk(8'h2a, 16'he4b0);
        $display("test field done");
    endtask
    // an event seen while the clock enable is low must never be latched
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        ev.manchester_error <= 1'b1;
        @(posedge clk);
        ev.manchester_error <= 1'b0;
        @(posedge clk);
        ce <= 1'b1;
        @(negedge clk);
        chk1(summ, 1'b0);
        rd_chk(8'h26, 16'hb000);
        $display("test freeze done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_packet();
        t_events();
        t_field();
        t_freeze();
        end_sim();
    end
    initial begin
        repeat (4000) @(posedge clk);
        fail_count++;
        end_sim();
    end
endmodule
`default_nettype wire
